// file: tb/ispr_bus_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: pull-ups on both lines, 200 ns clock period
// Notes: pulls lines low only
`timescale 1ns/1ps
`default_nettype none
module ispr_bus_master (
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// release clock, bounded wait for stretch
	task automatic rel();
		int n;
		scl_low = 1'b0;
		n = 0;
		while (!scl && n < 3000) begin
			#10;
			n++;
		end
	endtask
	task automatic pulse(input logic b, output logic seen);
		sda_low = !b;
		#40;
		rel();
		#80;
		seen = sda;
		scl_low = 1'b1;
		#80;
	endtask
	task automatic start_bit();
		sda_low = 1'b1;
		#80;
		scl_low = 1'b1;
		#40;
	endtask
	task automatic stop_bit();
		sda_low = 1'b1;
		#40;
		rel();
		#80;
		sda_low = 1'b0;
		#80;
	endtask
	// address or data byte, MSB first
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(d[i], s);
		pulse(1'b1, s);
		ack = !s;
	endtask
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
		pulse(!ack, s);
	endtask
endmodule
`default_nettype wire

// file: tb/ispr_slave_monitor.sv
// Purpose: port checker for the two-wire slave
// Assumes: bound to ispr_slave
// Notes: watches ports only
`timescale 1ns/1ps
`default_nettype none
module ispr_slave_monitor #(
	parameter [23:0] TO_UNIT = 24'h000400
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_SDA_LOW_ONLY: assert property (!sda_out)
		else $error("data line driven high");
	AST_SCL_LOW_ONLY: assert property (!scl_out)
		else $error("clock line driven high");
	AST_ACK_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data pulled while clock high");
	AST_STRETCH_ON_LOW: assert property ($rose(scl_oe) |-> !scl_in)
		else $error("stretch began while clock high");
	AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	AST_DATA_KEEP: assert property (wr && addr == 3'h3 ##1 rd && addr == 3'h3 |=> rdata == $past(wdata, 2))
		else $error("data register lost write");
	AST_ADDR_KEEP: assert property (wr && addr == 3'h2 ##1 rd && addr == 3'h2 |=> rdata == $past(wdata, 2))
		else $error("address register lost write");
	AST_CTRL0_GAP: assert property (rd && addr == 3'h0 |=> !rdata[4])
		else $error("unused control bit set");
	AST_STRETCH_FREE: assert property (scl_oe && (wr || rd) && addr == 3'h3 |-> ##[1:2] !scl_oe)
		else $error("stretch kept after data access");
endmodule
bind ispr_slave ispr_slave_monitor #(.TO_UNIT(TO_UNIT)) u_mon (.clk(clk), .reset(reset),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// file: tb/ispr_slave_tb.sv
// Purpose: self-checking bench of the two-wire slave
// Assumes: 100 MHz clock
// Notes: master model on the far side
`timescale 1ns/1ps
`default_nettype none
module ispr_slave_tb;
	logic clk, reset, wr, rd, a1, a2;
	logic [2:0] addr;
	logic [7:0] wdata, d, d2;
	wire [7:0] rdata;
	wire irq, scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
	wire scl_w = !(m_scl || (scl_oe && !scl_out));
	wire sda_w = !(m_sda || (sda_oe && !sda_out));
	int fails, checks_done;
	ispr_slave #(.TO_UNIT(24'h000010)) u_ispr_slave (.clk(clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
	ispr_bus_master u_ispr_bus_master (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wr_rd(input logic [2:0] a, input logic [7:0] v, output logic [7:0] r);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
	endtask
	task automatic wait_oe();
		int n;
		n = 0;
		while (scl_oe !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n == 2000) begin
			fails++;
			test_done();
		end
	endtask
	task automatic test_reset();
		rd_reg(3'h0, d); check("control zero", d, 8'he0);
		rd_reg(3'h1, d); check("control one", d, 8'h01);
		rd_reg(3'h4, d); check("time-out", d, 8'h00);
		rd_reg(3'h7, d); check("unmapped", d, 8'h00);
	endtask
	task automatic test_regs();
		wr_rd(3'h2, 8'ha5, d); check("address", d, 8'ha5);
		wr_rd(3'h3, 8'h5a, d); check("data", d, 8'h5a);
		wr_reg(3'h4, 8'h3f); rd_reg(3'h4, d); check("time-out", d, 8'h3f);
		wr_reg(3'h1, 8'hff); rd_reg(3'h1, d); check("control one", d, 8'h1b);
		wr_reg(3'h1, 8'h00);
	endtask
	task automatic test_write_xfer();
		wr_reg(3'h0, 8'hc2);
		wr_reg(3'h6, 8'h0f);
		fork
			begin
				u_ispr_bus_master.start_bit();
				u_ispr_bus_master.send_byte(8'ha4, a1);
				u_ispr_bus_master.send_byte(8'h3c, a2);
			end
			begin
				wait_oe();
				rd_reg(3'h1, d); check("status", d & 8'he4, 8'he0);
				check("irq", {7'h00, irq}, 8'h01);
				wr_reg(3'h3, 8'h00);
			end
		join
		check("address ack", {7'h00, a1}, 8'h01);
		check("data ack", {7'h00, a2}, 8'h01);
		fork
			u_ispr_bus_master.stop_bit();
			begin
				wait_oe();
				rd_reg(3'h3, d); check("received", d, 8'h3c);
			end
		join
		rd_reg(3'h1, d); check("busy", d & 8'h20, 8'h00);
	endtask
	task automatic test_read_xfer();
		fork
			begin
				u_ispr_bus_master.start_bit();
				u_ispr_bus_master.send_byte(8'ha5, a1);
				u_ispr_bus_master.recv_byte(1'b0, d2);
			end
			begin
				wait_oe();
				rd_reg(3'h1, d); check("master read", d & 8'h04, 8'h04);
				wr_reg(3'h1, 8'h10);
				wr_reg(3'h3, 8'h96);
			end
		join
		check("address ack", {7'h00, a1}, 8'h01);
		check("sent", d2, 8'h96);
		u_ispr_bus_master.stop_bit();
		check("no stretch", {7'h00, scl_oe}, 8'h00);
	endtask
	task automatic test_irq();
		check("irq", {7'h00, irq}, 8'h01);
		wr_reg(3'h6, 8'h00);
		repeat (2) @(posedge clk);
		check("irq masked", {7'h00, irq}, 8'h00);
		wr_reg(3'h5, 8'h0f);
		wr_reg(3'h6, 8'h0f);
		rd_reg(3'h5, d); check("irq status", d, 8'h00);
		check("irq cleared", {7'h00, irq}, 8'h00);
	endtask
	task automatic test_debounce();
		for (int k = 1; k < 4; k++) begin
			wr_reg(3'h0, 8'hc2 | (8'(k) << 2));
			u_ispr_bus_master.start_bit();
			u_ispr_bus_master.send_byte(8'hb0, a1);
			check("foreign address", {7'h00, a1}, 8'h00);
			u_ispr_bus_master.stop_bit();
		end
	endtask
	task automatic test_timeout();
		wr_reg(3'h4, 8'h80);
		u_ispr_bus_master.start_bit();
		repeat (40) @(posedge clk);
		rd_reg(3'h4, d); check("time-out flag", d, 8'hc0);
		rd_reg(3'h5, d); check("time-out irq", d & 8'h04, 8'h04);
		u_ispr_bus_master.stop_bit();
		wr_reg(3'h4, 8'h00);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		test_done();
	end
	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (5) @(posedge clk);
		test_reset();
		test_regs();
		test_write_xfer();
		test_read_xfer();
		test_irq();
		test_debounce();
		test_timeout();
		test_done();
	end
endmodule
`default_nettype wire

// file: verilog/ispr_filter.v
// Purpose: synchroniser and glitch filter for the bus clock line
// Assumes: raw pin is asynchronous to clk
// Notes: output idles high like a pulled-up line
`timescale 1ns/1ps
`default_nettype none
`include "ispr_map.vh"

module ispr_filter (
	input wire clk,
	input wire reset,
	input wire raw,
	input wire [1:0] sel,
	output reg level
);

reg sync_a;
reg sync_b;
reg [2:0] stable_cnt;
wire [2:0] need;

// ----------------------------------------
// debounce length
// ----------------------------------------
assign need = (sel == 2'h1) ? `ISPR_DEB_TWO : `ISPR_DEB_FOUR; // [R4]

always @(posedge clk) begin
	if (reset) begin
		sync_a <= 1'h1;
		sync_b <= 1'h1;
		stable_cnt <= 3'h0;
		level <= 1'h1;
	end else begin
		sync_a <= raw;
		sync_b <= sync_a;
		if (sel == 2'h0) begin
			level <= sync_b; // [R4]
			stable_cnt <= 3'h0;
		end else if (sync_b == level) begin
			stable_cnt <= 3'h0;
		end else if (stable_cnt == need - 3'h1) begin
			level <= sync_b; // [R14]
			stable_cnt <= 3'h0;
		end else begin
			stable_cnt <= stable_cnt + 3'h1;
		end
	end
end

endmodule
`default_nettype wire

// file: verilog/ispr_map.vh
// Purpose: register map and constants of the two-wire slave port
// Assumes: 8-bit registers on a plain strobe port, index addressing
// Notes: definitions only
//
// Function
// [R1] both bus lines open-drain, pull low only
// [R2] slave chosen by bus address, no select
// [R3] slave only: transmit and receive directions
// [R4] debounce select: none, 2 or 4 clocks
// [R5] standard mode needs fsys above 2/4/8 MHz
// [R6] fast mode needs fsys above 5/10/20 MHz
// [R7] one shared 8-bit data register
// [R8] address in bits 7..1, bit 0 plain storage
// [R9] selected when bus address matches stored address
// [R10] address register shares second control location; here it has its own offset 3'h2
// [R11] control zero: enable, mode, debounce
// [R12] control one: eight status flags, bit 7..0
// [R13] time-out: enable, flag, 6-bit period
// [R14] clock level accepted after stable debounce time
`ifndef ISPR_MAP_VH
`define ISPR_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ISPR_OFS_CTRL0 3'h0
`define ISPR_OFS_CTRL1 3'h1
`define ISPR_OFS_SADDR 3'h2
`define ISPR_OFS_DATA 3'h3
`define ISPR_OFS_TOC 3'h4
`define ISPR_OFS_ISTAT 3'h5
`define ISPR_OFS_IMASK 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define ISPR_C0_MODE 7:5
`define ISPR_C0_DEB 3:2
`define ISPR_C0_EN 1
`define ISPR_C0_ICF 0
`define ISPR_C1_HTX 4
`define ISPR_C1_ACK_TO_SEND 3
`define ISPR_C1_ADDRESS_MATCH_WAKEUP 1
`define ISPR_TO_EN 7
`define ISPR_TO_FLAG 6
`define ISPR_TO_SEL 5:0
`define ISPR_IRQ_BITS 3:0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ISPR_RST_MODE 3'h7
`define ISPR_RST_BYTE 8'h00
`define ISPR_MODE_TWO_WIRE 3'h6
`define ISPR_DEB_TWO 3'h2
`define ISPR_DEB_FOUR 3'h4
`define ISPR_TO_UNIT 24'h000400

`endif

// file: verilog/ispr_slave.v
// Purpose: two-wire bus slave with control, status and data registers
// Assumes: external master, pull-ups on both lines, 100 MHz clk
// Notes: clock line held low after each byte, except a transmitted byte the master NACKs, until data is accessed
`timescale 1ns/1ps
`default_nettype none
`include "ispr_map.vh"

module ispr_slave #(
	parameter [23:0] TO_UNIT = `ISPR_TO_UNIT
) (
	input wire clk,
	input wire reset,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	output reg irq,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe
);

// ----------------------------------------
// states
// ----------------------------------------
localparam [7:0] ST_IDLE = 8'h01;
localparam [7:0] ST_ADDR = 8'h02;
localparam [7:0] ST_AACK = 8'h04;
localparam [7:0] ST_RX = 8'h08;
localparam [7:0] ST_RACK = 8'h10;
localparam [7:0] ST_TX = 8'h20;
localparam [7:0] ST_TACK = 8'h40;
localparam [7:0] ST_HOLD = 8'h80;

// ----------------------------------------
// functions
// ----------------------------------------
function [3:0] sticky;
	input [3:0] cur;
	input [3:0] set;
	input [3:0] clr;
	begin
		sticky = (cur & ~clr) | set;
	end
endfunction

function [23:0] to_limit;
	input [5:0] sel;
	input [23:0] unit;
	reg [47:0] prod;
	begin
		prod = ({18'h0, sel} + 24'h1) * unit;
		to_limit = prod[23:0];
	end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [2:0] operating_mode_select;
reg [1:0] debounce_select;
reg interface_enable;
reg incomplete_transfer_flag;
reg transfer_complete_flag;
reg addressed_as_slave_flag;
reg bus_busy_flag;
reg transmit_direction;
reg ack_to_send;
reg master_rw_request;
reg address_match_wakeup;
reg received_ack;
reg [7:0] slave_address;
reg [7:0] shared_data;
reg timeout_enable;
reg timeout_flag;
reg [5:0] timeout_period_select;
reg [3:0] irq_status;
reg [3:0] irq_mask;
reg [7:0] state;
reg [3:0] bitcnt;
reg [7:0] shreg;
reg [23:0] to_cnt;
reg ev_tc;
reg ev_aas;
reg ev_to;
reg ev_icf;
reg sda_s1;
reg sda_s2;
reg sda_q;
reg scl_q;
wire scl_f;
wire active;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire data_acc;
wire to_expire;
wire [7:0] tx_byte;

// ----------------------------------------
// line conditioning
// ----------------------------------------
ispr_filter u_scl_filter (
	.clk(clk),
	.reset(reset),
	.raw(scl_in),
	.sel(debounce_select),
	.level(scl_f)
);

always @(posedge clk) begin
	if (reset) begin
		sda_s1 <= 1'h1;
		sda_s2 <= 1'h1;
		sda_q <= 1'h1;
		scl_q <= 1'h1;
	end else begin
		sda_s1 <= sda_in;
		sda_s2 <= sda_s1;
		sda_q <= sda_s2;
		scl_q <= scl_f;
	end
end

// open-drain: only the enables ever change
always @(posedge clk) begin
	sda_out <= 1'h0; // [R1]
	scl_out <= 1'h0; // [R1]
end

assign active = interface_enable && (operating_mode_select == `ISPR_MODE_TWO_WIRE); // [R11]
assign scl_rise = scl_f && !scl_q;
assign scl_fall = !scl_f && scl_q;
assign start_det = scl_f && scl_q && sda_q && !sda_s2;
assign stop_det = scl_f && scl_q && !sda_q && sda_s2;
assign data_acc = (wr || rd) && (addr == `ISPR_OFS_DATA); // [R7]
assign tx_byte = wr ? wdata : shared_data; // [R7]
assign to_expire = timeout_enable && bus_busy_flag &&
	(to_cnt >= to_limit(timeout_period_select, TO_UNIT)); // [R13]

// ----------------------------------------
// time-out counter
// ----------------------------------------
always @(posedge clk) begin
	if (reset) begin
		to_cnt <= 24'h0;
	end else if (!bus_busy_flag || !timeout_enable || scl_rise || scl_fall) begin
		to_cnt <= 24'h0;
	end else if (!to_expire) begin
		to_cnt <= to_cnt + 24'h1;
	end
end

// ----------------------------------------
// registers and bus engine
// ----------------------------------------
always @(posedge clk) begin
	if (reset) begin
		operating_mode_select <= `ISPR_RST_MODE;
		debounce_select <= 2'h0;
		interface_enable <= 1'h0;
		incomplete_transfer_flag <= 1'h0;
		transfer_complete_flag <= 1'h0;
		addressed_as_slave_flag <= 1'h0;
		bus_busy_flag <= 1'h0;
		transmit_direction <= 1'h0;
		ack_to_send <= 1'h0;
		master_rw_request <= 1'h0;
		address_match_wakeup <= 1'h0;
		received_ack <= 1'h1;
		slave_address <= `ISPR_RST_BYTE;
		shared_data <= `ISPR_RST_BYTE;
		timeout_enable <= 1'h0;
		timeout_flag <= 1'h0;
		timeout_period_select <= 6'h0;
		state <= ST_IDLE;
		bitcnt <= 4'h0;
		shreg <= 8'h00;
		sda_oe <= 1'h0;
		scl_oe <= 1'h0;
		ev_tc <= 1'h0;
		ev_aas <= 1'h0;
		ev_to <= 1'h0;
		ev_icf <= 1'h0;
	end else begin
		ev_tc <= 1'h0;
		ev_aas <= 1'h0;
		ev_to <= 1'h0;
		ev_icf <= 1'h0;
		if (wr) begin
			case (addr)
			`ISPR_OFS_CTRL0: begin
				operating_mode_select <= wdata[`ISPR_C0_MODE]; // [R11]
				debounce_select <= wdata[`ISPR_C0_DEB]; // [R4]
				interface_enable <= wdata[`ISPR_C0_EN]; // [R11]
				incomplete_transfer_flag <= wdata[`ISPR_C0_ICF];
			end
			`ISPR_OFS_CTRL1: begin
				transmit_direction <= wdata[`ISPR_C1_HTX]; // [R12]
				ack_to_send <= wdata[`ISPR_C1_ACK_TO_SEND]; // [R12]
				address_match_wakeup <= wdata[`ISPR_C1_ADDRESS_MATCH_WAKEUP]; // [R12]
			end
			`ISPR_OFS_SADDR: begin
				slave_address <= wdata; // [R8] [R10]
			end
			`ISPR_OFS_DATA: begin
				shared_data <= wdata; // [R7]
			end
			`ISPR_OFS_TOC: begin
				timeout_enable <= wdata[`ISPR_TO_EN]; // [R13]
				timeout_flag <= wdata[`ISPR_TO_FLAG];
				timeout_period_select <= wdata[`ISPR_TO_SEL]; // [R13]
			end
			default: begin
			end
			endcase
		end
		if (!active) begin
			state <= ST_IDLE;
			sda_oe <= 1'h0;
			scl_oe <= 1'h0;
			bus_busy_flag <= 1'h0;
			addressed_as_slave_flag <= 1'h0;
		end else if (to_expire) begin
			state <= ST_IDLE;
			sda_oe <= 1'h0;
			scl_oe <= 1'h0;
			bus_busy_flag <= 1'h0;
			addressed_as_slave_flag <= 1'h0;
			timeout_flag <= 1'h1; // [R13]
			ev_to <= 1'h1;
		end else if (start_det || stop_det) begin
			if (state != ST_IDLE && state != ST_HOLD && bitcnt > 4'h1) begin
				incomplete_transfer_flag <= 1'h1;
				ev_icf <= 1'h1;
			end
			state <= start_det ? ST_ADDR : ST_IDLE;
			bitcnt <= 4'h0;
			bus_busy_flag <= start_det; // [R12]
			addressed_as_slave_flag <= 1'h0;
			transfer_complete_flag <= 1'h0;
			sda_oe <= 1'h0;
			scl_oe <= 1'h0;
		end else if (state == ST_HOLD) begin
			if (data_acc) begin
				// software touched data: release clock, pick direction
				scl_oe <= 1'h0;
				transfer_complete_flag <= 1'h0;
				bitcnt <= 4'h0;
				if (transmit_direction) begin
					state <= ST_TX; // [R3]
					shreg <= tx_byte; // [R7]
					sda_oe <= !tx_byte[7]; // [R1]
				end else begin
					state <= ST_RX; // [R3]
				end
			end
		end else begin
			if (scl_rise) begin
				bitcnt <= bitcnt + 4'h1;
				if (state == ST_ADDR || state == ST_RX) begin
					shreg <= {shreg[6:0], sda_s2};
				end
				if (state == ST_TACK) begin
					received_ack <= sda_s2; // [R12]
				end
			end
			if (scl_fall) begin
				case (state)
				ST_ADDR: begin
					if (bitcnt == 4'h8) begin
						if (shreg[7:1] == slave_address[7:1]) begin
							state <= ST_AACK; // [R9] [R2]
							sda_oe <= 1'h1;
							addressed_as_slave_flag <= 1'h1;
							master_rw_request <= shreg[0];
							ev_aas <= 1'h1;
						end else begin
							state <= ST_IDLE; // [R2]
						end
					end
				end
				ST_AACK: begin
					sda_oe <= 1'h0;
					scl_oe <= 1'h1; // [R1]
					state <= ST_HOLD;
					transfer_complete_flag <= 1'h1;
					ev_tc <= 1'h1;
				end
				ST_RX: begin
					if (bitcnt == 4'h8) begin
						shared_data <= shreg; // [R7]
						sda_oe <= !ack_to_send;
						state <= ST_RACK;
					end
				end
				ST_RACK: begin
					sda_oe <= 1'h0;
					scl_oe <= 1'h1; // [R1]
					state <= ST_HOLD;
					transfer_complete_flag <= 1'h1;
					ev_tc <= 1'h1;
				end
				ST_TX: begin
					if (bitcnt == 4'h8) begin
						sda_oe <= 1'h0;
						state <= ST_TACK;
					end else begin
						shreg <= {shreg[6:0], 1'h0};
						sda_oe <= !shreg[6]; // [R1]
					end
				end
				ST_TACK: begin
					transfer_complete_flag <= 1'h1;
					ev_tc <= 1'h1;
					if (received_ack) begin
						state <= ST_IDLE;
					end else begin
						scl_oe <= 1'h1;
						state <= ST_HOLD;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end
end

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
always @(posedge clk) begin
	if (reset) begin
		irq_status <= 4'h0;
		irq_mask <= 4'h0;
		irq <= 1'h0;
	end else begin
		irq_status <= sticky(irq_status, {ev_icf, ev_to, ev_aas, ev_tc},
			(wr && addr == `ISPR_OFS_ISTAT) ? wdata[`ISPR_IRQ_BITS] : 4'h0);
		if (wr && addr == `ISPR_OFS_IMASK) begin
			irq_mask <= wdata[`ISPR_IRQ_BITS];
		end
		irq <= |(irq_status & irq_mask);
	end
end

// ----------------------------------------
// read port
// ----------------------------------------
always @(posedge clk) begin
	if (reset) begin
		rdata <= 8'h00;
	end else if (rd) begin
		case (addr)
		`ISPR_OFS_CTRL0: begin
			rdata <= {operating_mode_select, 1'h0, debounce_select,
				interface_enable, incomplete_transfer_flag}; // [R11]
		end
		`ISPR_OFS_CTRL1: begin
			rdata <= {transfer_complete_flag, addressed_as_slave_flag,
				bus_busy_flag, transmit_direction, ack_to_send,
				master_rw_request, address_match_wakeup, received_ack}; // [R12]
		end
		`ISPR_OFS_SADDR: begin
			rdata <= slave_address; // [R8]
		end
		`ISPR_OFS_DATA: begin
			rdata <= shared_data; // [R7]
		end
		`ISPR_OFS_TOC: begin
			rdata <= {timeout_enable, timeout_flag, timeout_period_select}; // [R13]
		end
		`ISPR_OFS_ISTAT: begin
			rdata <= {4'h0, irq_status};
		end
		`ISPR_OFS_IMASK: begin
			rdata <= {4'h0, irq_mask};
		end
		default: begin
			rdata <= 8'h00;
		end
		endcase
	end else begin
		rdata <= 8'h00;
	end
end

endmodule
`default_nettype wire
